// ### arpc_defs.svh
/*
  Holds the offsets, field positions, reset values and timing counts of the result port.
  Assumes the includer has a 50 MHz clock.
*/
`ifndef ARPC_DEFS_SVH
`define ARPC_DEFS_SVH

// apb register byte offsets
`define ARPC_OFS_RESULT   8'h00
`define ARPC_OFS_STATUS   8'h04

// status register fields
`define ARPC_ST_BUSY      0
`define ARPC_ST_FRAME     1
`define ARPC_ST_SERIAL    2
`define ARPC_ST_EXTCLK    3
`define ARPC_ST_CHAIN     4

`define ARPC_RESULT_RST   16'h0000

// data pin positions reused by the serial port
`define ARPC_PIN_DIV0     2
`define ARPC_PIN_DIV1     3
`define ARPC_PIN_CLKSRC   4
`define ARPC_PIN_FRMPOL   5
`define ARPC_PIN_CLKINV   6
`define ARPC_PIN_RDC      7
`define ARPC_PIN_SOUT     8
`define ARPC_PIN_SCLK     9

`define ARPC_LAST_BIT     5'd15
`define ARPC_END_CNT      5'd16

// timing
`define ARPC_CLK_NS       20
`define ARPC_SCLK_HIGH_NS 12
`define ARPC_SCLK_HALF_CYC ((`ARPC_SCLK_HIGH_NS + `ARPC_CLK_NS - 1) / `ARPC_CLK_NS)
`define ARPC_CONV_NS      2000
`define ARPC_CONV_CYC     (`ARPC_CONV_NS / `ARPC_CLK_NS)

`endif

// ### arpc_pkg.sv
/*
  Types shared by the result port modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package arpc_pkg;
    typedef logic [15:0] arpc_word_t;
    typedef enum logic [1:0] {
        SER_IDLE,
        SER_SHIFT,
        SER_CHAIN
    } arpc_ser_state_t;
endpackage

// ### arpc_cfg_if.sv
/*
  Carries the decoded port configuration and serial levels from the top to the pin mux.
  Assumes the top drives every field.
*/
`timescale 1ns/1ps
`default_nettype none
interface arpc_cfg_if;
    import arpc_pkg::*;
    logic       interfaceSelect;
    logic       halfSwap;
    arpc_word_t word;
    logic       serialBit;
    logic       sclkLevel;
    logic       extClock;
    modport src (output interfaceSelect, halfSwap, word, serialBit, sclkLevel, extClock);
    modport mux (input interfaceSelect, halfSwap, word, serialBit, sclkLevel, extClock);
endinterface
`default_nettype wire

// ### arpc_pin_mux.sv
/*
  Computes the next level and drive enable of each shared data pin.
  Assumes the caller registers the results before they reach the pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arpc_defs.svh"
module arpc_pin_mux (
    arpc_cfg_if.mux           cfg,
    output logic [15:0]       nextDOut,
    output logic [15:0]       nextDOe
);
    always_comb begin
        nextDOut = 16'h0000;
        nextDOe  = 16'h0000;
        if (!cfg.interfaceSelect) begin
            nextDOe = 16'hffff;
            if (cfg.halfSwap) begin
                nextDOut = {cfg.word[7:0], cfg.word[15:8]};
            end else begin
                nextDOut = cfg.word;
            end
        end else begin
            // pins 0 and 1 float, pins 2..7 become select inputs
            nextDOut[`ARPC_PIN_SOUT] = cfg.serialBit;
            nextDOe[`ARPC_PIN_SOUT]  = 1'b1;
            nextDOut[`ARPC_PIN_SCLK] = cfg.sclkLevel;
            nextDOe[`ARPC_PIN_SCLK]  = !cfg.extClock;
        end
    end
endmodule
`default_nettype wire

// ### arpc_sclk_div.sv
/*
  Divider giving one-cycle ticks at each internal serial clock half period.
  Assumes run is held for the whole serial frame.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arpc_defs.svh"
module arpc_sclk_div #(
    parameter int unsigned HALF_CYC = `ARPC_SCLK_HALF_CYC
)(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [1:0] div,
    output logic            tick
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] limit;
    logic       next_tick;

    always_comb begin
        limit     = 8'((HALF_CYC << div) - 1);
        next_cnt  = 8'h00;
        next_tick = 1'b0;
        if (run) begin
            if (cnt >= limit) begin
                next_tick = 1'b1;
            end else begin
                next_cnt = 8'(cnt + 8'h01);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= 8'h00;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// ### arpc_result_port.sv
/*
  Result port of a converter: apb-loaded result, parallel or serial output on shared pins.
  Assumes pin inputs are synchronous to clk and the host keeps the selects static during a read.
*/
// Added by the designer: the register addresses and register access over APB.
// Operation
// - swap low: low byte on lines 7..0
// - swap high: byte lanes exchanged
// - coding high: straight binary output
// - coding low: msb inverted, twos complement
// - interface low: parallel outputs drive pins
// - interface high: pins become serial port
// - serial mode: data bits 0,1 float
// - internal after-convert: divider slows serial clock
// - other serial modes ignore divider
// - parallel: divider pins drive bits 2,3
// - parallel: select pins drive bits 4..7
// - internal source: drive serial clock out
// - external source: follow host serial clock
// - frame polarity low: frame active high
// - frame polarity high: frame active low
// - clock invert flips serial clock polarity
// - read timing picks during/after conversion
// - external clock: chain input after 16
// - result shifted out msb first
// - update on rising, inverted on falling
`timescale 1ns/1ps
`default_nettype none
`include "arpc_defs.svh"
module arpc_result_port
    import arpc_pkg::*;
#(
    parameter int unsigned CONV_CYC = `ARPC_CONV_CYC
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        interfaceSelect,
    input  wire logic        halfSwapSelect,
    input  wire logic        outputCodingSelect,
    input  wire logic [15:0] dIn,
    output logic [15:0]      dOut,
    output logic [15:0]      dOe,
    output logic             frameOut
);
    localparam int CW = $clog2(CONV_CYC + 1);

    arpc_cfg_if cfg ();

    arpc_word_t      result;
    arpc_word_t      next_result;
    arpc_word_t      pending;
    arpc_word_t      next_pending;
    logic [CW-1:0]   convCnt;
    logic [CW-1:0]   next_convCnt;
    logic [31:0]     next_prdata;
    logic            next_pready;
    logic            next_pslverr;
    arpc_ser_state_t state;
    arpc_ser_state_t next_state;
    arpc_word_t      shiftReg;
    arpc_word_t      next_shiftReg;
    logic [4:0]      bitCnt;
    logic [4:0]      next_bitCnt;
    logic            sclkInt;
    logic            next_sclkInt;
    logic            sclkPrev;
    logic [15:0]     next_dOut;
    logic [15:0]     next_dOe;
    logic            next_frameOut;

    logic            apbAcc;
    logic            apbWrite;
    logic            convStart;
    logic            convEnd;
    logic            busy;
    logic            extMode;
    logic            frmPol;
    logic            clkInv;
    logic            rdc;
    logic [1:0]      effDiv;
    logic            tick;
    logic            upd;
    logic            startRead;
    arpc_word_t      loadWord;

    function automatic arpc_word_t coded(input arpc_word_t w, input logic straight);
        coded = {w[15] ^ !straight, w[14:0]};
    endfunction

    // apb slave, one wait state per access
    assign apbAcc    = psel && penable;
    assign apbWrite  = apbAcc && pready && pwrite;
    assign convStart = apbWrite && (paddr == `ARPC_OFS_RESULT);
    assign busy      = (convCnt != '0);
    assign convEnd   = (convCnt == CW'(1));

    always_comb begin
        next_pready  = apbAcc && !pready;
        next_pslverr = 1'b0;
        next_prdata  = prdata;
        next_result  = result;
        next_pending = pending;
        next_convCnt = convCnt;
        if (apbAcc && !pready) begin
            next_prdata = 32'h0000_0000;
            case (paddr)
                `ARPC_OFS_RESULT: begin
                    next_prdata[15:0] = result;
                end
                `ARPC_OFS_STATUS: begin
                    next_prdata[`ARPC_ST_BUSY]   = busy;
                    next_prdata[`ARPC_ST_FRAME]  = (state == SER_SHIFT);
                    next_prdata[`ARPC_ST_SERIAL] = interfaceSelect;
                    next_prdata[`ARPC_ST_EXTCLK] = extMode;
                    next_prdata[`ARPC_ST_CHAIN]  = (state == SER_CHAIN);
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
        // a write to the result register starts a conversion
        if (convStart) begin
            next_pending = pwdata[15:0];
            next_convCnt = CW'(CONV_CYC);
        end else if (busy) begin
            next_convCnt = CW'(convCnt - CW'(1));
        end
        if (convEnd) begin
            next_result = pending;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            result  <= `ARPC_RESULT_RST;
            pending <= `ARPC_RESULT_RST;
            convCnt <= '0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            result  <= next_result;
            pending <= next_pending;
            convCnt <= next_convCnt;
        end
    end

    // serial selects read from the shared pins
    assign extMode = interfaceSelect && dIn[`ARPC_PIN_CLKSRC];
    assign frmPol  = interfaceSelect && dIn[`ARPC_PIN_FRMPOL];
    assign clkInv  = interfaceSelect && dIn[`ARPC_PIN_CLKINV];
    assign rdc     = interfaceSelect && dIn[`ARPC_PIN_RDC];
    assign effDiv  = (interfaceSelect && !extMode && !rdc) ?
                     {dIn[`ARPC_PIN_DIV1], dIn[`ARPC_PIN_DIV0]} : 2'b00;

    arpc_sclk_div u_div (
        .clk   (clk),
        .rst_n (rst_n),
        .run   ((state == SER_SHIFT) && !extMode),
        .div   (effDiv),
        .tick  (tick)
    );

    // internal clock: update on internal rise, which is the pin fall when inverted
    // external clock: update on the pin edge that moves to the non-inverted high
    assign upd = extMode ?
                 ((dIn[`ARPC_PIN_SCLK] != sclkPrev) && (dIn[`ARPC_PIN_SCLK] == !clkInv)) :
                 (tick && !sclkInt);

    assign startRead = interfaceSelect && (state != SER_SHIFT) &&
                       ((!extMode && rdc) ? convStart : convEnd);
    assign loadWord  = (!extMode && rdc) ? result : pending;

    always_comb begin
        next_state    = state;
        next_shiftReg = shiftReg;
        next_bitCnt   = bitCnt;
        next_sclkInt  = sclkInt;
        case (state)
            SER_IDLE: begin
                next_sclkInt = 1'b0;
            end
            SER_SHIFT: begin
                if (tick) begin
                    next_sclkInt = !sclkInt;
                end
                if (upd) begin
                    next_shiftReg = {shiftReg[14:0], extMode && rdc};
                    next_bitCnt   = 5'(bitCnt + 5'd1);
                    if (extMode && bitCnt == `ARPC_LAST_BIT) begin
                        next_state = SER_CHAIN;
                    end
                end
                // internal clock: the 16th pulse still rises, the frame ends on its fall
                if (!extMode && tick && sclkInt && bitCnt == `ARPC_END_CNT) begin
                    next_state   = SER_IDLE;
                    next_sclkInt = 1'b0;
                end
            end
            SER_CHAIN: begin
                if (upd) begin
                    next_shiftReg = {shiftReg[14:0], rdc};
                end
                if (!extMode) begin
                    next_state = SER_IDLE;
                end
            end
            default: begin
                next_state = SER_IDLE;
            end
        endcase
        if (startRead) begin
            next_state    = SER_SHIFT;
            next_shiftReg = coded(loadWord, outputCodingSelect);
            next_bitCnt   = 5'd0;
            next_sclkInt  = 1'b0;
        end else if (!interfaceSelect) begin
            next_state = SER_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= SER_IDLE;
            shiftReg <= 16'h0000;
            bitCnt   <= 5'd0;
            sclkInt  <= 1'b0;
            sclkPrev <= 1'b0;
        end else begin
            state    <= next_state;
            shiftReg <= next_shiftReg;
            bitCnt   <= next_bitCnt;
            sclkInt  <= next_sclkInt;
            sclkPrev <= dIn[`ARPC_PIN_SCLK];
        end
    end

    // pins
    assign cfg.interfaceSelect = interfaceSelect;
    assign cfg.halfSwap        = halfSwapSelect;
    assign cfg.word            = coded(result, outputCodingSelect);
    assign cfg.serialBit       = shiftReg[15];
    assign cfg.sclkLevel       = sclkInt ^ clkInv;
    assign cfg.extClock        = extMode;

    arpc_pin_mux u_mux (
        .cfg      (cfg),
        .nextDOut (next_dOut),
        .nextDOe  (next_dOe)
    );

    always_comb begin
        next_frameOut = interfaceSelect && ((state == SER_SHIFT) ^ frmPol);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dOut     <= 16'h0000;
            dOe      <= 16'h0000;
            frameOut <= 1'b0;
        end else begin
            dOut     <= next_dOut;
            dOe      <= next_dOe;
            frameOut <= next_frameOut;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_load;
        startRead ##1 (state == SER_SHIFT);
    endsequence

    a_par_drive_all: assert property (rst_n && !interfaceSelect |=> dOe == 16'hffff)
        else $error("parallel mode does not drive all data pins");
    a_low_pins_float: assert property (interfaceSelect |=> dOe[1:0] == 2'b00)
        else $error("bits 0 and 1 driven in serial mode");
    a_cfg_pins_in: assert property (interfaceSelect |=> dOe[7:2] == 6'h00)
        else $error("serial select pins are driven");
    a_lane_order: assert property (!interfaceSelect && !halfSwapSelect |=>
        dOut == coded($past(result), $past(outputCodingSelect)))
        else $error("unswapped lanes wrong");
    a_lane_swap: assert property (!interfaceSelect && halfSwapSelect |=>
        dOut[7:0] == ($past(result[15:8]) ^ {!$past(outputCodingSelect), 7'h00}))
        else $error("swapped lanes wrong");
    a_msb_coding: assert property (!interfaceSelect && !halfSwapSelect |=>
        dOut[15] == ($past(result[15]) ^ !$past(outputCodingSelect)))
        else $error("msb coding wrong");
    a_sclk_source: assert property (interfaceSelect |=> dOe[`ARPC_PIN_SCLK] == !$past(extMode))
        else $error("serial clock drive does not follow source select");
    a_frame_level: assert property (interfaceSelect && state == SER_SHIFT |=> frameOut == !$past(frmPol))
        else $error("frame level wrong while active");
    a_div_ignored: assert property (interfaceSelect && (extMode || rdc) |-> effDiv == 2'b00)
        else $error("divider used outside read after conversion");
    a_after_conv: assert property (startRead && !extMode && !rdc |-> convEnd)
        else $error("read after conversion started early");
    a_msb_first: assert property (s_load |=> dOut[`ARPC_PIN_SOUT] == $past(shiftReg[15]))
        else $error("first serial bit is not the msb");
    a_chain_shift: assert property (upd && extMode && state != SER_IDLE && !startRead |=>
        shiftReg[0] == $past(rdc))
        else $error("chain input not shifted in");
    a_update_edge: assert property ($past(state == SER_SHIFT) && !$past(extMode) && !$past(startRead)
        && $changed(shiftReg) |-> $rose(sclkInt))
        else $error("serial data moved off the update edge");
endmodule
`default_nettype wire

// ### arpc_host_model.sv
/*
  Behavioural host on the serial side of the result port: drives the select pins,
  the serial clock when external, and collects serial bits.
  Assumes the bench resolves the shared pins from dOe, dOut and hostOe, hostPins.
*/
`timescale 1ns/1ps
`default_nettype none
module arpc_host_model (
    input  wire logic        clk,
    input  wire logic        serial,
    input  wire logic        extClk,
    input  wire logic        frmPol,
    input  wire logic        clkInv,
    input  wire logic        readTiming,
    input  wire logic [1:0]  div,
    input  wire logic [15:0] dOut,
    output logic [15:0]      hostPins,
    output logic [15:0]      hostOe
);
    logic        hostSclk = 1'b0;
    logic        prevSclk = 1'b0;
    logic        prevData = 1'b0;
    logic [15:0] rx       = 16'h0000;
    int          gap      = 1;
    int          lastGap  = 0;
    logic        sclkPin;

    // select levels are static between reads; bench changes them only when idle
    always_comb begin
        hostPins    = 16'h0000;
        hostPins[3:2] = div;
        hostPins[4] = extClk;
        hostPins[5] = frmPol;
        hostPins[6] = clkInv;
        hostPins[7] = readTiming;
        hostPins[9] = hostSclk;
        hostOe      = serial ? (extClk ? 16'h02fc : 16'h00fc) : 16'h0000;
    end

    assign sclkPin = extClk ? hostSclk : dOut[9];

    // take the bit shown before each active edge, then note the half period
    always @(posedge clk) begin
        if (sclkPin !== prevSclk && sclkPin === !clkInv) begin
            rx <= {rx[14:0], prevData};
        end
        if (sclkPin !== prevSclk) begin
            lastGap <= gap;
            gap     <= 1;
        end else begin
            gap <= gap + 1;
        end
        prevSclk <= sclkPin;
        prevData <= dOut[8];
    end

    // host clock, half period of three cycles, still outside the call
    task automatic ext_clock(input int n);
        repeat (n) begin
            repeat (3) @(posedge clk);
            hostSclk <= !clkInv;
            repeat (3) @(posedge clk);
            hostSclk <= clkInv;
        end
    endtask
endmodule
`default_nettype wire

// ### adc_result_port_config_bench.sv
/*
  Self-checking bench for the result port: apb loads results, parallel and serial reads.
  Assumes arpc_host_model stands on the serial side.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_result_port_config_bench;
    logic        clk = 1'b0, rst_n = 1'b0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic        interfaceSelect = 0, halfSwapSelect = 0, outputCodingSelect = 1;
    logic        extClk = 0, frmPol = 0, clkInv = 0, readTiming = 0;
    logic [1:0]  div = 2'b00;
    logic [15:0] dIn, dOut, dOe, hostPins, hostOe, c;
    logic        frameOut;
    int          n_mismatch = 0, checks = 0;

    always #10 clk = ~clk;
    // floating pins show the inverse of the last level
    assign dIn = (dOe & dOut) | (~dOe & hostOe & hostPins) | (~dOe & ~hostOe & ~dOut);

    arpc_result_port #(.CONV_CYC(5)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .interfaceSelect(interfaceSelect), .halfSwapSelect(halfSwapSelect),
        .outputCodingSelect(outputCodingSelect), .dIn(dIn), .dOut(dOut), .dOe(dOe), .frameOut(frameOut));
    arpc_host_model i_host (.clk(clk), .serial(interfaceSelect), .extClk(extClk), .frmPol(frmPol),
        .clkInv(clkInv), .readTiming(readTiming), .div(div), .dOut(dOut), .hostPins(hostPins),
        .hostOe(hostOe));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 0;
        @(posedge clk);
        penable <= 1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) n_mismatch++;
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask

    task automatic wait_frame(input logic lvl);
        int n;
        n = 0;
        while (frameOut !== lvl && n < 300) begin @(posedge clk); n++; end
        chk(frameOut, lvl);
    endtask

    function automatic logic [15:0] coded(input logic [15:0] v, input logic ob);
        return ob ? v : v ^ 16'h8000;
    endfunction

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b1, 8'h00, 32'h0000_a17c);
        do apb(1'b0, 8'h04, 32'h0); while (rd[0] !== 1'b0 && checks == 0 && $time < 20000);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0000_a17c);
        apb(1'b0, 8'h08, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            halfSwapSelect <= i[0]; outputCodingSelect <= i[1];
            repeat (3) @(posedge clk);
            c = coded(16'ha17c, i[1]);
            chk(dOe, 16'hffff);
            chk(dOut, i[0] ? {c[7:0], c[15:8]} : c);
        end
        interfaceSelect <= 1'b1; outputCodingSelect <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            frmPol <= i[0]; clkInv <= i[0]; div <= i[0] ? 2'b10 : 2'b00;
            repeat (4) @(posedge clk);
            chk(dOe, 16'h0300);
            apb(1'b1, 8'h00, 32'h0000_b3c5 ^ i);
            wait_frame(!i[0]);
            wait_frame(i[0]);
            chk(i_host.rx, coded(16'hb3c5 ^ 16'(i), 1'b0));
            chk(i_host.lastGap, i[0] ? 4 : 1);
        end
        frmPol <= 1'b0; clkInv <= 1'b0; div <= 2'b11; readTiming <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b1, 8'h00, 32'h0000_5e21);
        wait_frame(1'b1);
        wait_frame(1'b0);
        chk(i_host.rx, coded(16'hb3c4, 1'b0));
        chk(i_host.lastGap, 1);
        extClk <= 1'b1; frmPol <= 1'b1; outputCodingSelect <= 1'b1;
        repeat (4) @(posedge clk);
        chk(dOe, 16'h0100);
        apb(1'b1, 8'h00, 32'h0000_c69d);
        wait_frame(1'b0);
        i_host.ext_clock(20);
        chk(i_host.rx, {12'h69d, 4'hf});
        results();
    end
endmodule
`default_nettype wire
